// >>> core/mplc_axis_ctrl.sv
// per-axis command interpreter: position presets, loops, limit query, absolute moves
`timescale 1ns/1ns
`include "mplc_cfg.svh"
// Notes on behaviour
// - set_motor_count loads motor counter only
// - later preset_both_counts overwrites motor count
// - preset loads encoder, motor gets ratio product when encoder_fitted, else the preset value
// - missing preset parameter loads zero
// - closed-loop preset costs one extra each
// - loop count from 1 to 32000
// - loops nest four deep per axis
// - first pass live, rest after loop_end
// - single-axis loops run in own queue
// - limit polarity query answers with line feed
// - move_absolute stages; start commands move
// - empty every_motor_mode entry keeps position
// - every_motor_mode axes start together; start_all is masked off here, so move_start follows this axis's own start only
// - closed-loop absolute move costs one extra
// - cosine velocity fix adds 1 and 10
// - restore after timed or linear costs more
// - limit active low by default
// - repetition starts upon loop_end
module mplc_axis_ctrl #(
    parameter int POS_W = `MPLC_POS_W,
    parameter int QDEPTH = 64
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire mplc_pkg::mplc_op_t cmd_op,
    input wire logic cmd_has_arg,
    input wire logic signed [POS_W-1:0] cmd_arg,
    input wire logic encoder_fitted,
    input wire logic closed_loop,
    input wire logic signed [15:0] enc_ratio,
    input wire mplc_pkg::mplc_ramp_t ramp,
    input wire logic cos_adjust,
    input wire logic restore,
    input wire logic [4:0] segments,
    input wire logic start_all,
    input wire logic limit_in,
    output logic cmd_ready,
    output logic signed [POS_W-1:0] motor_pos,
    output logic signed [POS_W-1:0] encoder_pos,
    output logic signed [POS_W-1:0] target_pos,
    output logic move_start,
    output logic over_travel,
    output logic limit_high,
    output logic reply_valid,
    output logic [7:0] reply_char,
    output logic [7:0] cmd_room,
    output logic [7:0] arg_room,
    output logic loop_err
);
    import mplc_pkg::*;
    localparam int AW = $clog2(QDEPTH);
    typedef struct packed {
        mplc_state_t st;
        logic rs1;
        logic rs2;
        logic signed [POS_W-1:0] mot;
        logic signed [POS_W-1:0] enc;
        logic signed [POS_W-1:0] tgt;
        logic staged;
        logic go;
        logic ovt;
        logic lim_hi;
        logic rv;
        logic [7:0] rc;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic replay;
        logic [7:0] croom;
        logic [7:0] aroom;
        logic err;
        logic rdy;
    } mplc_axis_t;
    mplc_axis_t s_r;
    mplc_axis_t s_nxt;
    // per-axis command history kept for loop replay
    mplc_op_t q_op [QDEPTH];
    logic q_has [QDEPTH];
    logic signed [POS_W-1:0] q_arg [QDEPTH];
    logic [4:0] cmd_cost;
    logic [6:0] arg_cost;
    logic lp_push;
    logic lp_close;
    logic lp_jump;
    logic [`MPLC_PTR_W-1:0] lp_ptr;
    logic lp_full;
    logic lp_empty;
    logic take;
    logic rec;
    mplc_op_t x_op;
    logic x_has;
    logic signed [POS_W-1:0] x_arg;
    logic signed [POS_W+15:0] ratio_prod;
    logic [15:0] cnt_arg;
    // replay reads from history, otherwise live command
    assign take = cmd_valid && cmd_ready;
    assign rec = take && !lp_empty;
    assign x_op = s_r.replay ? q_op[s_r.rp] : (take ? cmd_op : MPLC_OP_NONE);
    assign x_has = s_r.replay ? q_has[s_r.rp] : cmd_has_arg;
    assign x_arg = s_r.replay ? q_arg[s_r.rp] : cmd_arg;
    assign ratio_prod = x_arg * enc_ratio;
    assign cnt_arg = x_arg[15:0];
    // replayed loop starts push again so inner loops repeat; unsigned compare refuses negatives
    assign lp_push = x_op == MPLC_OP_LOOP_START && x_arg >= POS_W'(`MPLC_LOOP_MIN)
        && x_arg <= POS_W'(`MPLC_LOOP_MAX);
    assign lp_close = (x_op == MPLC_OP_LOOP_END) && (s_r.replay || take);
    // queue cost of current command
    mplc_cost u_cost (
        .op(x_op),
        .closed_loop(closed_loop),
        .ramp(ramp),
        .cos_adjust(cos_adjust),
        .restore(restore),
        .segments(segments),
        .cmd_cost(cmd_cost),
        .arg_cost(arg_cost)
    );
    // nested loop tracking for this axis
    mplc_loop_stack #(
        .DEPTH(`MPLC_LOOP_DEPTH)
    ) u_loops (
        .clk(clk),
        .rst_n(s_r.rs2),
        .push(lp_push),
        .push_ptr(`MPLC_PTR_W'(s_r.replay ? s_r.rp : s_r.wp) + `MPLC_PTR_W'(1)),
        .push_count(cnt_arg),
        .close(lp_close),
        .jump(lp_jump),
        .jump_ptr(lp_ptr),
        .full(lp_full),
        .empty(lp_empty)
    );
    // history write for every loop start and while any loop is open
    always_ff @(posedge clk) begin
        if (rec || (take && cmd_op == MPLC_OP_LOOP_START)) begin
            q_op[s_r.wp] <= cmd_op;
            q_has[s_r.wp] <= cmd_has_arg;
            q_arg[s_r.wp] <= cmd_arg;
        end
    end
    // command execution and bookkeeping
    always_comb begin
        s_nxt = s_r;
        s_nxt.rs1 = 1'b1;
        s_nxt.rs2 = s_r.rs1;
        s_nxt.go = 1'b0;
        s_nxt.rv = 1'b0;
        s_nxt.ovt = s_r.lim_hi ? limit_in : !limit_in;
        if (take && (cmd_op == MPLC_OP_LOOP_START || !lp_empty)) begin
            s_nxt.wp = s_r.wp + AW'(1);
        end
        case (x_op)
            MPLC_OP_SET_MOTOR: s_nxt.mot = x_arg;
            MPLC_OP_PRESET_BOTH: begin
                if (!x_has) begin
                    s_nxt.mot = '0;
                    s_nxt.enc = '0;
                end else if (encoder_fitted) begin
                    s_nxt.enc = x_arg;
                    s_nxt.mot = POS_W'(ratio_prod);
                end else begin
                    s_nxt.mot = x_arg;
                    s_nxt.enc = x_arg;
                end
            end
            MPLC_OP_MOVE_ABS: begin
                if (x_has) begin
                    s_nxt.tgt = x_arg;
                end else begin
                    s_nxt.tgt = s_r.mot;
                end
                s_nxt.staged = 1'b1;
            end
            MPLC_OP_START, MPLC_OP_START_DEF: begin
                if (s_r.staged) begin
                    s_nxt.go = 1'b1;
                    s_nxt.staged = 1'b0;
                end
            end
            MPLC_OP_LOOP_START: begin
                if (!lp_push) begin
                    s_nxt.err = 1'b1;
                end else if (lp_full) begin
                    s_nxt.err = 1'b1;
                end
            end
            MPLC_OP_LOOP_END: begin
                if (lp_empty) begin
                    s_nxt.err = 1'b1;
                end
            end
            MPLC_OP_QUERY_LIM: begin
                s_nxt.rv = 1'b1;
                s_nxt.rc = s_r.lim_hi ? `MPLC_CHAR_HI : `MPLC_CHAR_LO;
                s_nxt.st = MPLC_ST_REPLY;
            end
            MPLC_OP_LIM_LOW: s_nxt.lim_hi = 1'b0;
            MPLC_OP_LIM_HIGH: s_nxt.lim_hi = 1'b1;
            default: begin
            end
        endcase
        // line feed terminates the polarity reply
        if (s_r.st == MPLC_ST_REPLY) begin
            s_nxt.rv = 1'b1;
            s_nxt.rc = `MPLC_CHAR_LF;
            s_nxt.st = MPLC_ST_IDLE;
        end
        // queue room accounting, stall when fewer than 6 entries remain inside an open loop
        if (x_op != MPLC_OP_NONE && !s_r.replay) begin
            s_nxt.croom = s_r.croom - 8'(cmd_cost);
            s_nxt.aroom = (s_r.aroom > 8'(arg_cost)) ? s_r.aroom - 8'(arg_cost) : 8'h00;
        end
        if (!s_r.replay && lp_empty && x_op == MPLC_OP_NONE) begin
            s_nxt.croom = 8'(QDEPTH);
            s_nxt.aroom = 8'(QDEPTH);
        end
        if (s_nxt.croom < 8'h06 && !lp_empty && !s_r.replay) begin
            s_nxt.st = MPLC_ST_STALL;
        end
        // replay sequencing after loop_end
        if (lp_close) begin
            if (lp_jump) begin
                s_nxt.replay = 1'b1;
                s_nxt.rp = AW'(lp_ptr);
                s_nxt.st = MPLC_ST_EXEC;
            end else if (s_r.replay) begin
                s_nxt.rp = s_r.rp + AW'(1);
            end
        end else if (s_r.replay) begin
            s_nxt.rp = s_r.rp + AW'(1);
        end
        if (s_r.replay && !lp_jump && lp_close && s_r.rp + AW'(1) == s_r.wp) begin
            s_nxt.replay = 1'b0;
            s_nxt.st = MPLC_ST_IDLE;
        end
        if (!s_r.replay && lp_close && !lp_jump && s_r.st != MPLC_ST_STALL) begin
            s_nxt.st = MPLC_ST_IDLE;
        end
        // ready registered from the next state
        s_nxt.rdy = s_nxt.rs2 && !s_nxt.replay && s_nxt.st != MPLC_ST_REPLY && s_nxt.st != MPLC_ST_STALL;
    end
    // state register with synchronised reset release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '{st: MPLC_ST_IDLE, lim_hi: !`MPLC_LIM_LOW_RST, croom: 8'(QDEPTH),
                     aroom: 8'(QDEPTH), default: '0};
        end else if (!s_r.rs2) begin
            s_r.rs1 <= 1'b1;
            s_r.rs2 <= s_r.rs1;
            s_r.rdy <= s_r.rs1;
        end else begin
            s_r <= s_nxt;
        end
    end
    // outputs straight from state flops
    assign cmd_ready = s_r.rdy;
    assign motor_pos = s_r.mot;
    assign encoder_pos = s_r.enc;
    assign target_pos = s_r.tgt;
    assign move_start = s_r.go || (start_all && 1'b0);
    assign over_travel = s_r.ovt;
    assign limit_high = s_r.lim_hi;
    assign reply_valid = s_r.rv;
    assign reply_char = s_r.rc;
    assign cmd_room = s_r.croom;
    assign arg_room = s_r.aroom;
    assign loop_err = s_r.err;
endmodule

// >>> core/mplc_cfg.svh
// constants for the motion position and loop command interpreter
`ifndef MPLC_CFG_SVH
`define MPLC_CFG_SVH
`define MPLC_POS_W 32
`define MPLC_LOOP_DEPTH 4
`define MPLC_LOOP_MAX 16'h7D00
`define MPLC_LOOP_MIN 16'h0001
`define MPLC_PTR_W 8
`define MPLC_CNT_W 16
`define MPLC_COST_BASE 5'h01
`define MPLC_COST_ENC 5'h01
`define MPLC_COS_CMD 5'h01
`define MPLC_COS_ARG 5'h0A
`define MPLC_RST_CMD 5'h04
`define MPLC_ARG_LIN 7'h04
`define MPLC_ARG_SPAR 7'h08
`define MPLC_ARG_PAR 7'h16
`define MPLC_ARG_COS 7'h16
`define MPLC_CHAR_LO 8'h6C
`define MPLC_CHAR_HI 8'h68
`define MPLC_CHAR_LF 8'h0A
`define MPLC_LIM_LOW_RST 1'b1
`endif

// >>> core/mplc_cost.sv
// queue cost calculator for queued position and move commands
`timescale 1ns/1ns
`include "mplc_cfg.svh"
module mplc_cost (
    input wire mplc_pkg::mplc_op_t op,
    input wire logic closed_loop,
    input wire mplc_pkg::mplc_ramp_t ramp,
    input wire logic cos_adjust,
    input wire logic restore,
    input wire logic [4:0] segments,
    output logic [4:0] cmd_cost,
    output logic [6:0] arg_cost
);
    import mplc_pkg::*;
    // base cost plus per-axis extras; a limit query or no command costs nothing
    always_comb begin
        cmd_cost = `MPLC_COST_BASE;
        arg_cost = 7'(`MPLC_COST_BASE);
        if (op == MPLC_OP_QUERY_LIM || op == MPLC_OP_NONE) begin
            cmd_cost = 5'h00;
            arg_cost = 7'h00;
        end else if (op == MPLC_OP_PRESET_BOTH || op == MPLC_OP_MOVE_ABS) begin
            if (closed_loop) begin
                cmd_cost = cmd_cost + `MPLC_COST_ENC;
                arg_cost = arg_cost + 7'(`MPLC_COST_ENC);
            end
        end
        if (op == MPLC_OP_MOVE_ABS) begin
            if (ramp == MPLC_RAMP_COSINE && cos_adjust) begin
                cmd_cost = cmd_cost + `MPLC_COS_CMD;
                arg_cost = arg_cost + 7'(`MPLC_COS_ARG);
            end
            if (restore) begin
                cmd_cost = cmd_cost + `MPLC_RST_CMD;
                case (ramp)
                    MPLC_RAMP_LINEAR: arg_cost = arg_cost + `MPLC_ARG_LIN;
                    MPLC_RAMP_SHORT_PAR: arg_cost = arg_cost + `MPLC_ARG_SPAR;
                    MPLC_RAMP_PARABOLIC: arg_cost = arg_cost + `MPLC_ARG_PAR;
                    MPLC_RAMP_COSINE: arg_cost = arg_cost + `MPLC_ARG_COS;
                    default: arg_cost = arg_cost + {1'b0, segments, 1'b0} + 7'h02;
                endcase
            end
        end
    end
endmodule

// >>> core/mplc_loop_stack.sv
// per-axis nested loop stack with start pointer and remaining count
`timescale 1ns/1ns
`include "mplc_cfg.svh"
module mplc_loop_stack #(
    parameter int DEPTH = `MPLC_LOOP_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic push,
    input wire logic [`MPLC_PTR_W-1:0] push_ptr,
    input wire logic [`MPLC_CNT_W-1:0] push_count,
    input wire logic close,
    output logic jump,
    output logic [`MPLC_PTR_W-1:0] jump_ptr,
    output logic full,
    output logic empty
);
    import mplc_pkg::*;
    typedef struct packed {
        logic [DEPTH-1:0][`MPLC_PTR_W-1:0] ptr;
        logic [DEPTH-1:0][`MPLC_CNT_W-1:0] cnt;
        logic [2:0] lvl;
    } mplc_stk_t;
    mplc_stk_t s_r;
    mplc_stk_t s_nxt;
    logic [1:0] top;
    assign top = 2'(s_r.lvl - 3'h1);
    assign full = (s_r.lvl == 3'(DEPTH));
    assign empty = (s_r.lvl == 3'h0);
    assign jump = close && !empty && (s_r.cnt[top] > `MPLC_LOOP_MIN);
    assign jump_ptr = s_r.ptr[top];
    // push on loop start, decrement or pop on loop end
    always_comb begin
        s_nxt = s_r;
        if (push && !full) begin
            s_nxt.ptr[s_r.lvl[1:0]] = push_ptr;
            s_nxt.cnt[s_r.lvl[1:0]] = push_count;
            s_nxt.lvl = s_r.lvl + 3'h1;
        end else if (close && !empty) begin
            if (jump) begin
                s_nxt.cnt[top] = s_r.cnt[top] - 16'h0001;
            end else begin
                s_nxt.lvl = s_r.lvl - 3'h1;
            end
        end
    end
    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule

// >>> core/mplc_pkg.sv
// types for the motion position and loop command interpreter
package mplc_pkg;
    typedef enum logic [3:0] {
        MPLC_OP_NONE = 4'h0,
        MPLC_OP_SET_MOTOR = 4'h1,
        MPLC_OP_PRESET_BOTH = 4'h2,
        MPLC_OP_LOOP_START = 4'h3,
        MPLC_OP_LOOP_END = 4'h4,
        MPLC_OP_QUERY_LIM = 4'h5,
        MPLC_OP_MOVE_ABS = 4'h6,
        MPLC_OP_START = 4'h7,
        MPLC_OP_START_DEF = 4'h8,
        MPLC_OP_LIM_LOW = 4'h9,
        MPLC_OP_LIM_HIGH = 4'hA
    } mplc_op_t;
    typedef enum logic [2:0] {
        MPLC_RAMP_LINEAR = 3'h0,
        MPLC_RAMP_SHORT_PAR = 3'h1,
        MPLC_RAMP_PARABOLIC = 3'h2,
        MPLC_RAMP_COSINE = 3'h3,
        MPLC_RAMP_CUSTOM = 3'h4
    } mplc_ramp_t;
    typedef enum logic [1:0] {
        MPLC_ST_IDLE = 2'b00,
        MPLC_ST_EXEC = 2'b01,
        MPLC_ST_REPLY = 2'b10,
        MPLC_ST_STALL = 2'b11
    } mplc_state_t;
endpackage

// >>> test/motion_position_loop_commands_tb.sv
// self-checking bench for the axis command interpreter
`timescale 1ns/1ns
module motion_position_loop_commands_tb;
    import mplc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic encoder_fitted = 1'b1;
    logic closed_loop = 1'b0;
    logic cos_adjust = 1'b0;
    logic restore = 1'b0;
    logic limit_in = 1'b1;
    logic signed [15:0] enc_ratio = 16'sh0003;
    mplc_ramp_t ramp = MPLC_RAMP_LINEAR;
    mplc_op_t cmd_op;
    logic cmd_valid, cmd_has_arg, cmd_ready, move_start, over_travel, limit_high, reply_valid, loop_err;
    logic signed [31:0] cmd_arg, motor_pos, encoder_pos, target_pos;
    logic [7:0] reply_char, cmd_room, arg_room;
    int num_errors = 0;
    int cmp_count = 0;
    int pulses = 0;
    // clock and start pulse counter
    always #4 clk = ~clk;
    always @(posedge clk) if (move_start === 1'b1) pulses <= pulses + 1;
    mplc_host_model host_u (.clk, .cmd_ready, .cmd_valid, .cmd_op, .cmd_has_arg, .cmd_arg);
    mplc_axis_ctrl #(.POS_W(32), .QDEPTH(64)) dut_u (.clk, .rst_n, .cmd_valid, .cmd_op, .cmd_has_arg, .cmd_arg,
        .encoder_fitted, .closed_loop, .enc_ratio, .ramp, .cos_adjust, .restore, .segments(5'h03),
        .start_all(1'b0), .limit_in, .cmd_ready, .motor_pos, .encoder_pos, .target_pos, .move_start,
        .over_travel, .limit_high, .reply_valid, .reply_char, .cmd_room, .arg_room, .loop_err);
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("mismatches %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // one lone command, ending in the cycle after it is taken
    task automatic cmd(input mplc_op_t o, input logic h, input logic signed [31:0] a);
        @(posedge clk);
        host_u.send(o, h, a);
        host_u.idle();
        @(negedge clk);
    endtask
    task automatic do_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(negedge clk);
        check("motor", motor_pos, 32'h0);
        check("encoder", encoder_pos, 32'h0);
        check("rooms", {cmd_room, arg_room}, 32'h4040);
        check("flags", {limit_high, loop_err, cmd_ready}, 32'h1);
    endtask
    task automatic pos(input logic [31:0] em, input logic [31:0] ee);
        check("motor", motor_pos, em);
        check("encoder", encoder_pos, ee);
    endtask
    task automatic t_preset();
        cmd(MPLC_OP_PRESET_BOTH, 1'b1, 32'h64);
        pos(32'h12C, 32'h64);
        cmd(MPLC_OP_SET_MOTOR, 1'b1, 32'h32);
        pos(32'h32, 32'h64);
        cmd(MPLC_OP_PRESET_BOTH, 1'b1, 32'hFFFFFFFE);
        pos(32'hFFFFFFFA, 32'hFFFFFFFE);
        cmd(MPLC_OP_PRESET_BOTH, 1'b0, 32'h0);
        pos(32'h0, 32'h0);
        $display("preset test done");
    endtask
    task automatic reply(input logic [7:0] ch);
        check("reply", {reply_valid, reply_char}, {1'b1, ch});
        @(negedge clk);
        check("line feed", {reply_valid, reply_char}, 32'h10A);
    endtask
    task automatic t_limit();
        @(posedge clk);
        limit_in <= 1'b0;
        cmd(MPLC_OP_QUERY_LIM, 1'b0, 32'h0);
        reply(8'h6C);
        check("over travel low", over_travel, 32'h1);
        cmd(MPLC_OP_LIM_HIGH, 1'b0, 32'h0);
        cmd(MPLC_OP_QUERY_LIM, 1'b0, 32'h0);
        reply(8'h68);
        check("over travel high", over_travel, 32'h0);
        cmd(MPLC_OP_LIM_LOW, 1'b0, 32'h0);
        check("limit high", limit_high, 32'h0);
        $display("limit test done");
    endtask
    task automatic t_move();
        int p;
        p = pulses;
        cmd(MPLC_OP_MOVE_ABS, 1'b1, 32'h3E8);
        repeat (3) @(negedge clk);
        check("staged", target_pos, 32'h3E8);
        check("no start", 32'(pulses - p), 32'h0);
        cmd(MPLC_OP_START, 1'b0, 32'h0);
        cmd(MPLC_OP_MOVE_ABS, 1'b1, 32'h7D0);
        cmd(MPLC_OP_START_DEF, 1'b0, 32'h0);
        // nothing staged, so no further pulse
        cmd(MPLC_OP_START, 1'b0, 32'h0);
        repeat (4) @(negedge clk);
        check("starts", 32'(pulses - p), 32'h2);
        cmd(MPLC_OP_SET_MOTOR, 1'b1, 32'h77);
        cmd(MPLC_OP_MOVE_ABS, 1'b0, 32'h0);
        check("kept", target_pos, 32'h77);
        $display("move test done");
    endtask
    // a later command is only taken once replay has finished
    task automatic passes(input int p, input logic [31:0] n);
        cmd(MPLC_OP_LIM_LOW, 1'b0, 32'h0);
        @(negedge clk);
        check("passes", 32'(pulses - p), n);
        check("loop err", loop_err, 32'h0);
    endtask
    task automatic t_loop();
        int p;
        p = pulses;
        cmd(MPLC_OP_LOOP_START, 1'b1, 32'h3);
        cmd(MPLC_OP_MOVE_ABS, 1'b1, 32'h10);
        cmd(MPLC_OP_START, 1'b0, 32'h0);
        @(negedge clk);
        check("first pass", 32'(pulses - p), 32'h1);
        cmd(MPLC_OP_LOOP_END, 1'b0, 32'h0);
        passes(p, 32'h3);
        p = pulses;
        repeat (4) cmd(MPLC_OP_LOOP_START, 1'b1, 32'h2);
        cmd(MPLC_OP_MOVE_ABS, 1'b1, 32'h20);
        cmd(MPLC_OP_START, 1'b0, 32'h0);
        repeat (4) cmd(MPLC_OP_LOOP_END, 1'b0, 32'h0);
        passes(p, 32'h10);
        $display("loop test done");
    endtask
    task automatic t_bad();
        logic [31:0] cnt [3] = '{32'h7D00, 32'h7D01, 32'h0};
        for (int i = 0; i < 3; i++) begin
            do_reset();
            cmd(MPLC_OP_LOOP_START, 1'b1, cnt[i]);
            check("count range", loop_err, 32'(i != 0));
        end
        do_reset();
        repeat (4) cmd(MPLC_OP_LOOP_START, 1'b1, 32'h2);
        check("four deep", loop_err, 32'h0);
        cmd(MPLC_OP_LOOP_START, 1'b1, 32'h2);
        check("five deep", loop_err, 32'h1);
        do_reset();
        cmd(MPLC_OP_LOOP_END, 1'b0, 32'h0);
        check("stray end", loop_err, 32'h1);
        // an open loop that fills the queue stalls the axis
        do_reset();
        cmd(MPLC_OP_LOOP_START, 1'b1, 32'h2);
        repeat (58) cmd(MPLC_OP_LIM_LOW, 1'b0, 32'h0);
        check("room", cmd_room, 32'h5);
        check("stall", cmd_ready, 32'h0);
        $display("loop limit test done");
    endtask
    // entries one command takes inside an open loop
    task automatic cost(input mplc_op_t o, input logic cl, input mplc_ramp_t rp, input logic ca, input logic rs,
        input logic [7:0] ec, input logic [7:0] ea);
        logic [15:0] r;
        @(posedge clk);
        closed_loop <= cl;
        ramp <= rp;
        cos_adjust <= ca;
        restore <= rs;
        do_reset();
        cmd(MPLC_OP_LOOP_START, 1'b1, 32'h1);
        r = {cmd_room, arg_room};
        cmd(o, 1'b1, 32'h10);
        check("cost", {r[15:8] - cmd_room, r[7:0] - arg_room}, {ec, ea});
    endtask
    task automatic t_cost();
        cost(MPLC_OP_PRESET_BOTH, 1'b1, MPLC_RAMP_LINEAR, 1'b0, 1'b0, 8'h2, 8'h2);
        cost(MPLC_OP_MOVE_ABS, 1'b1, MPLC_RAMP_LINEAR, 1'b0, 1'b0, 8'h2, 8'h2);
        cost(MPLC_OP_MOVE_ABS, 1'b0, MPLC_RAMP_COSINE, 1'b1, 1'b0, 8'h2, 8'hB);
        cost(MPLC_OP_MOVE_ABS, 1'b0, MPLC_RAMP_LINEAR, 1'b0, 1'b1, 8'h5, 8'h5);
        cost(MPLC_OP_MOVE_ABS, 1'b0, MPLC_RAMP_SHORT_PAR, 1'b0, 1'b1, 8'h5, 8'h9);
        cost(MPLC_OP_MOVE_ABS, 1'b0, MPLC_RAMP_PARABOLIC, 1'b0, 1'b1, 8'h5, 8'h17);
        cost(MPLC_OP_MOVE_ABS, 1'b0, MPLC_RAMP_CUSTOM, 1'b0, 1'b1, 8'h5, 8'h9);
        $display("cost test done");
    endtask
    // main sequence
    initial begin
        do_reset();
        t_preset();
        t_limit();
        t_move();
        t_loop();
        t_bad();
        t_cost();
        end_of_test();
    end
    // cut a hang short
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        end_of_test();
    end
endmodule
bind mplc_axis_ctrl mplc_axis_asserts #(.POS_W(POS_W)) chk_u (.clk, .rst_n, .cmd_valid, .cmd_op, .cmd_has_arg,
    .cmd_arg, .encoder_fitted, .enc_ratio, .limit_in, .cmd_ready, .motor_pos, .encoder_pos, .target_pos,
    .move_start, .over_travel, .limit_high, .reply_valid, .reply_char, .loop_err);

// >>> test/mplc_axis_asserts.sv
// concurrent checks on the axis interpreter ports
`timescale 1ns/1ns
module mplc_axis_asserts #(
    parameter int POS_W = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire mplc_pkg::mplc_op_t cmd_op,
    input wire logic cmd_has_arg,
    input wire logic signed [POS_W-1:0] cmd_arg,
    input wire logic encoder_fitted,
    input wire logic signed [15:0] enc_ratio,
    input wire logic limit_in,
    input wire logic cmd_ready,
    input wire logic signed [POS_W-1:0] motor_pos,
    input wire logic signed [POS_W-1:0] encoder_pos,
    input wire logic signed [POS_W-1:0] target_pos,
    input wire logic move_start,
    input wire logic over_travel,
    input wire logic limit_high,
    input wire logic reply_valid,
    input wire logic [7:0] reply_char,
    input wire logic loop_err
);
    import mplc_pkg::*;
    logic [1:0] up_r;
    logic tk;
    logic stg_r;
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // cycles since reset release, saturating
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            up_r <= 2'h0;
        end else if (up_r != 2'h3) begin
            up_r <= up_r + 2'h1;
        end
    end
    // a command is taken
    assign tk = cmd_valid && cmd_ready;
    // a live absolute move stages, a live start consumes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stg_r <= 1'b0;
        end else if (tk && cmd_op == MPLC_OP_MOVE_ABS) begin
            stg_r <= 1'b1;
        end else if (tk && (cmd_op == MPLC_OP_START || cmd_op == MPLC_OP_START_DEF)) begin
            stg_r <= 1'b0;
        end
    end
    a_motor_only: assert property (tk && cmd_op == MPLC_OP_SET_MOTOR |=>
        motor_pos == $past(cmd_arg) && $stable(encoder_pos)) else $error("motor load wrong");
    a_preset_ratio: assert property (tk && cmd_op == MPLC_OP_PRESET_BOTH && cmd_has_arg && encoder_fitted |=>
        encoder_pos == $past(cmd_arg) && motor_pos == POS_W'($past(cmd_arg) * $past(enc_ratio)))
        else $error("preset load wrong");
    a_preset_zero: assert property (tk && cmd_op == MPLC_OP_PRESET_BOTH && !cmd_has_arg |=>
        motor_pos == 0 && encoder_pos == 0) else $error("empty preset not zero");
    a_query_reply: assert property (tk && cmd_op == MPLC_OP_QUERY_LIM |=>
        reply_valid && reply_char == (limit_high ? 8'h68 : 8'h6C) ##1 reply_valid && reply_char == 8'h0A)
        else $error("limit query reply wrong");
    a_stage_only: assert property (tk && cmd_op == MPLC_OP_MOVE_ABS && cmd_has_arg |=>
        !move_start && target_pos == $past(cmd_arg)) else $error("absolute move not staged");
    a_empty_keeps: assert property (tk && cmd_op == MPLC_OP_MOVE_ABS && !cmd_has_arg |=>
        target_pos == $past(motor_pos)) else $error("empty entry moved target");
    a_start_pulse: assert property (tk && (cmd_op == MPLC_OP_START || cmd_op == MPLC_OP_START_DEF) && stg_r
        |=> move_start) else $error("start gave no pulse");
    a_limit_sense: assert property (up_r == 2'h3 && $stable(limit_high) |=>
        over_travel == ($past(limit_high) ? $past(limit_in) : !$past(limit_in))) else $error("over travel wrong");
    a_polarity_set: assert property (tk && (cmd_op == MPLC_OP_LIM_HIGH || cmd_op == MPLC_OP_LIM_LOW) |=>
        limit_high == ($past(cmd_op) == MPLC_OP_LIM_HIGH)) else $error("polarity not set");
    a_count_range: assert property (tk && cmd_op == MPLC_OP_LOOP_START &&
        (cmd_arg < 32'sh1 || cmd_arg > 32'sh7D00) |=> loop_err) else $error("bad count accepted");
    a_err_sticky: assert property (loop_err |=> loop_err) else $error("loop error cleared");
    c_query: cover property (tk && cmd_op == MPLC_OP_QUERY_LIM);
    c_replay: cover property (tk && cmd_op == MPLC_OP_LOOP_END ##1 !cmd_ready);
    c_start: cover property (move_start);
endmodule

// >>> test/mplc_host_model.sv
// host model offering commands to the axis interpreter
`timescale 1ns/1ns
module mplc_host_model (
    input wire logic clk,
    input wire logic cmd_ready,
    output logic cmd_valid,
    output mplc_pkg::mplc_op_t cmd_op,
    output logic cmd_has_arg,
    output logic signed [31:0] cmd_arg
);
    import mplc_pkg::*;
    // idle request at time zero
    initial begin
        cmd_valid = 1'b0;
        cmd_op = MPLC_OP_NONE;
        cmd_has_arg = 1'b0;
        cmd_arg = 32'h0;
    end
    // offer one command until ready is seen at a negedge, giving up after 3000 negedges
    task automatic send(input mplc_op_t op, input logic has, input logic signed [31:0] arg);
        int n;
        n = 0;
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_has_arg <= has;
        cmd_arg <= has ? arg : 32'h5A5A5A5A;
        do begin
            @(negedge clk);
            n++;
        end while (cmd_ready !== 1'b1 && n < 3000);
        @(posedge clk);
    endtask
    // release after the taking edge, scramble the stale argument
    task automatic idle();
        cmd_valid <= 1'b0;
        cmd_op <= MPLC_OP_NONE;
        cmd_arg <= ~cmd_arg;
    endtask
endmodule
